// ### rtl/tug_guard.sv
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`include "tug_defines.svh"

// Function
// - host presents eight-byte key over debug port
// - option pair permanently disables temporary unlock
// - each key byte is one 8-bit option byte
// - counter writable only while unit is disabled
// - wrong key increments counter while unit enabled
// - counter reaching eight erases flash and eeprom
// - 55/aa loader pair forces loader start
module tug_guard
  import tug_pkg::*;
#(
  parameter tug_byte_t FAIL_LIMIT = `TUG_FAIL_LIMIT // erase threshold
)
(
  input wire logic clk_i,                 // system clock
  input wire logic rst_i,                 // sync reset, high
  input wire logic wb_cyc_i,              // bus cycle
  input wire logic wb_stb_i,              // bus strobe
  input wire logic wb_we_i,               // write enable
  input wire logic [7:0] wb_adr_i,        // byte address
  input wire logic [3:0] wb_sel_i,        // byte lanes
  input wire tug_pkg::tug_word_t wb_dat_i, // write data
  output logic [31:0] wb_dat_o,           // read data
  output logic wb_ack_o,                  // bus acknowledge
  input wire logic dbg_start_i,           // new key presentation
  input wire logic dbg_byte_valid_i,      // key byte strobe
  input wire tug_pkg::tug_byte_t dbg_byte_i, // key byte
  input wire logic code_programmed_i,     // code memory not blank
  output logic access_grant_o,            // temporary read access
  output logic erase_o,                   // erase pulse
  output logic loader_start_o             // start bootloader
);
  import tug_pkg::*;

  tug_key_if kif ();

  tug_byte_t key_reg [0:7];
  tug_byte_t key_next [0:7];
  tug_byte_t cnt_reg, cnt_next;
  tug_byte_t ldr_reg, ldr_next;
  tug_byte_t ldr_n_reg, ldr_n_next;
  tug_byte_t opt_reg, opt_next;
  tug_byte_t opt_n_reg, opt_n_next;
  logic perm_reg, perm_next;
  logic grant_reg, grant_next;
  logic erased_reg, erased_next;
  logic erase_reg, erase_next;
  logic loader_reg, loader_next;
  logic ack_reg, ack_next;
  tug_word_t rdat_reg, rdat_next;
  tug_idx_t idx;
  logic bus_req;
  logic wr_en;
  logic unit_off;
  logic key_bad;
  logic attempt;
  tug_byte_t cnt_inc;
  tug_word_t status;
  tug_key_t key_flat;

  // bus decode, a write lands at the edge where ack is seen high
  assign idx = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_en = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0];

  // unit disabled field in the option byte
  assign unit_off = opt_reg[3:0] == `TUG_UNIT_OFF_CODE;

  // stored key flattened for the comparator
  always_comb
  begin
    key_flat = '0;
    key_bad = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      key_flat[i*8 +: 8] = key_reg[i];
      if (key_reg[i] == `TUG_KEY_ZERO || key_reg[i] == `TUG_KEY_ONES)
      begin
        key_bad = 1'b1;
      end
    end
  end

  // key stream handed to the comparator
  assign kif.start = dbg_start_i;
  assign kif.byte_valid = dbg_byte_valid_i;
  assign kif.byte_data = dbg_byte_i;
  assign kif.stored = key_flat;

  tug_key_cmp u_cmp (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .kif(kif)
  );

  // an attempt counts only while the unit can act
  assign attempt = kif.done && !unit_off && !perm_reg && !grant_reg;
  assign cnt_inc = cnt_reg + 8'h01;

  // status word
  always_comb
  begin
    status = '0;
    status[`TUG_SB_GRANT] = grant_reg;
    status[`TUG_SB_PERM] = perm_reg;
    status[`TUG_SB_UNIT_OFF] = unit_off;
    status[`TUG_SB_KEY_BAD] = key_bad;
    status[`TUG_SB_ERASED] = erased_reg;
  end

  // option byte storage and register writes
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      key_next[i] = key_reg[i];
    end
    ldr_next = ldr_reg;
    ldr_n_next = ldr_n_reg;
    opt_next = opt_reg;
    opt_n_next = opt_n_reg;
    if (wr_en)
    begin
      if (idx <= `TUG_IDX_KEY_LAST)
      begin
        key_next[idx[2:0]] = wb_dat_i[7:0];
      end
      else if (idx == `TUG_IDX_LDR)
      begin
        ldr_next = wb_dat_i[7:0];
      end
      else if (idx == `TUG_IDX_LDR_N)
      begin
        ldr_n_next = wb_dat_i[7:0];
      end
      else if (idx == `TUG_IDX_OPT && !perm_reg)
      begin
        opt_next = wb_dat_i[7:0];
      end
      else if (idx == `TUG_IDX_OPT_N && !perm_reg)
      begin
        opt_n_next = wb_dat_i[7:0];
      end
    end
  end

  // failed-attempt counter, grant and erase
  always_comb
  begin
    cnt_next = cnt_reg;
    grant_next = grant_reg;
    erased_next = erased_reg;
    erase_next = 1'b0;
    perm_next = perm_reg;
    // locked pair: option byte code with a true complement
    if (opt_reg == `TUG_PERM_CODE && opt_n_reg == ~opt_reg)
    begin
      perm_next = 1'b1;
    end
    if (wr_en && idx == `TUG_IDX_CNT && unit_off)
    begin
      cnt_next = wb_dat_i[7:0];
    end
    if (attempt)
    begin
      if (kif.match)
      begin
        grant_next = 1'b1;
      end
      else if (cnt_reg < FAIL_LIMIT)
      begin
        cnt_next = cnt_inc;
        if (cnt_inc == FAIL_LIMIT)
        begin
          erase_next = 1'b1;
          erased_next = 1'b1;
        end
      end
    end
  end

  // loader force pair
  always_comb
  begin
    loader_next = !code_programmed_i;
    if (ldr_reg == `TUG_LDR_CODE && ldr_n_reg == `TUG_LDR_N_CODE)
    begin
      loader_next = 1'b1;
    end
  end

  // bus answer one cycle after the request
  always_comb
  begin
    ack_next = bus_req;
    rdat_next = '0;
    if (bus_req && !wb_we_i)
    begin
      if (idx <= `TUG_IDX_KEY_LAST)
      begin
        rdat_next[7:0] = key_reg[idx[2:0]];
      end
      else
      begin
        unique case (idx)
          `TUG_IDX_CNT: rdat_next[7:0] = cnt_reg;
          `TUG_IDX_LDR: rdat_next[7:0] = ldr_reg;
          `TUG_IDX_LDR_N: rdat_next[7:0] = ldr_n_reg;
          `TUG_IDX_OPT: rdat_next[7:0] = opt_reg;
          `TUG_IDX_OPT_N: rdat_next[7:0] = opt_n_reg;
          `TUG_IDX_STAT: rdat_next = status;
          default: rdat_next = '0;
        endcase
      end
    end
  end

  // option byte registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++)
      begin
        key_reg[i] <= `TUG_RST_BYTE;
      end
      ldr_reg <= `TUG_RST_BYTE;
      ldr_n_reg <= `TUG_RST_BYTE;
      opt_reg <= `TUG_RST_OPT;
      opt_n_reg <= `TUG_RST_OPT_N;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        key_reg[i] <= key_next[i];
      end
      ldr_reg <= ldr_next;
      ldr_n_reg <= ldr_n_next;
      opt_reg <= opt_next;
      opt_n_reg <= opt_n_next;
    end
  end

  // counter, lock, grant and erase registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= `TUG_RST_BYTE;
      perm_reg <= 1'b0;
      grant_reg <= 1'b0;
      erased_reg <= 1'b0;
      erase_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      perm_reg <= perm_next;
      grant_reg <= grant_next;
      erased_reg <= erased_next;
      erase_reg <= erase_next;
    end
  end

  // loader register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loader_reg <= 1'b0;
    end
    else
    begin
      loader_reg <= loader_next;
    end
  end

  // bus answer registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg <= 1'b0;
      rdat_reg <= '0;
    end
    else
    begin
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // outputs straight from flip-flops
  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign access_grant_o = grant_reg;
  assign erase_o = erase_reg;
  assign loader_start_o = loader_reg;
endmodule // tug_guard

// ### rtl/tug_defines.svh
`ifndef TUG_DEFINES_SVH
`define TUG_DEFINES_SVH

// register word indices, byte address is index times four
`define TUG_IDX_KEY_LAST 6'h07
`define TUG_IDX_CNT 6'h08
`define TUG_IDX_LDR 6'h09
`define TUG_IDX_LDR_N 6'h0a
`define TUG_IDX_OPT 6'h0b
`define TUG_IDX_OPT_N 6'h0c
`define TUG_IDX_STAT 6'h0d

// status bit positions
`define TUG_SB_GRANT 3'h0
`define TUG_SB_PERM 3'h1
`define TUG_SB_UNIT_OFF 3'h2
`define TUG_SB_KEY_BAD 3'h3
`define TUG_SB_ERASED 3'h4

// option byte codes
`define TUG_UNIT_OFF_CODE 4'b0101
`define TUG_PERM_CODE 8'haa
`define TUG_LDR_CODE 8'h55
`define TUG_LDR_N_CODE 8'haa
`define TUG_KEY_ZERO 8'h00
`define TUG_KEY_ONES 8'hff

// reset values and erase threshold
`define TUG_RST_BYTE 8'h00
`define TUG_RST_OPT 8'h00
`define TUG_RST_OPT_N 8'hff
`define TUG_FAIL_LIMIT 8'h08

`endif

// ### rtl/tug_pkg.sv
package tug_pkg;
  typedef logic [7:0] tug_byte_t;
  typedef logic [31:0] tug_word_t;
  typedef logic [5:0] tug_idx_t;
  typedef logic [63:0] tug_key_t;
  typedef enum logic [0:0] {TUG_CMP_IDLE, TUG_CMP_COLLECT} tug_cmp_state_t;
endpackage

// ### rtl/tug_key_if.sv
interface tug_key_if;
  import tug_pkg::*;
  logic start;
  logic byte_valid;
  tug_byte_t byte_data;
  tug_key_t stored;
  logic done;
  logic match;
  modport top (output start, byte_valid, byte_data, stored,
               input done, match);
  modport cmp (input start, byte_valid, byte_data, stored,
               output done, match);
endinterface

// ### rtl/tug_key_cmp.sv
module tug_key_cmp
  import tug_pkg::*;
(
  input wire logic clk_i, // system clock
  input wire logic rst_i, // sync reset, high
  tug_key_if.cmp kif      // key stream and verdict
);
  tug_cmp_state_t state_reg, state_next;
  logic [2:0] idx_reg, idx_next;
  logic bad_reg, bad_next;
  logic done_reg, done_next;
  logic match_reg, match_next;
  logic byte_bad;

  // presented byte against stored byte at the same position
  assign byte_bad = kif.byte_data != kif.stored[idx_reg*8 +: 8];

  // collect eight bytes, first byte is key byte one
  always_comb
  begin
    state_next = state_reg;
    idx_next = idx_reg;
    bad_next = bad_reg;
    done_next = 1'b0;
    match_next = match_reg;
    unique case (state_reg)
      TUG_CMP_IDLE:
      begin
        if (kif.start)
        begin
          state_next = TUG_CMP_COLLECT;
          idx_next = 3'h0;
          bad_next = 1'b0;
        end
      end
      TUG_CMP_COLLECT:
      begin
        if (kif.start)
        begin
          idx_next = 3'h0;
          bad_next = 1'b0;
        end
        else if (kif.byte_valid)
        begin
          idx_next = idx_reg + 3'h1;
          bad_next = bad_reg | byte_bad;
          if (idx_reg == 3'h7)
          begin
            state_next = TUG_CMP_IDLE;
            done_next = 1'b1;
            match_next = !(bad_reg | byte_bad);
          end
        end
      end
    endcase
  end

  // register stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= TUG_CMP_IDLE;
      idx_reg <= 3'h0;
      bad_reg <= 1'b0;
      done_reg <= 1'b0;
      match_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      bad_reg <= bad_next;
      done_reg <= done_next;
      match_reg <= match_next;
    end
  end

  assign kif.done = done_reg;
  assign kif.match = match_reg;
endmodule // tug_key_cmp

// ### tb/tug_guard_asserts.sv
module tug_guard_asserts (
  input wire logic clk_i, // clock
  input wire logic rst_i, // reset
  input wire logic wb_cyc_i, // cycle
  input wire logic wb_stb_i, // strobe
  input wire logic [31:0] wb_dat_o, // data
  input wire logic wb_ack_o, // ack
  input wire logic dbg_byte_valid_i, // byte
  input wire logic code_programmed_i, // code
  input wire logic access_grant_o, // grant
  input wire logic erase_o, // erase
  input wire logic loader_start_o // loader
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // bus request and its answer
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ans;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  property p_ack;
    s_req |=> s_ans;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus answer wrong");
  property p_dat;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat: assert property (p_dat)
    else $error("data outside ack");
  property p_akc;
    wb_ack_o |-> $past(wb_stb_i);
  endproperty
  a_akc: assert property (p_akc)
    else $error("ack without request");
  // verdict outputs
  property p_grant;
    access_grant_o |=> access_grant_o;
  endproperty
  a_grant: assert property (p_grant)
    else $error("grant dropped");
  property p_gcause;
    $rose(access_grant_o) |-> $past(dbg_byte_valid_i, 2);
  endproperty
  a_gcause: assert property (p_gcause)
    else $error("grant off time");
  property p_erase;
    erase_o |=> !erase_o;
  endproperty
  a_erase: assert property (p_erase)
    else $error("erase too long");
  property p_ecause;
    erase_o |-> $past(dbg_byte_valid_i, 2) && !access_grant_o;
  endproperty
  a_ecause: assert property (p_ecause)
    else $error("erase off time");
  property p_ldr;
    !code_programmed_i && !$past(rst_i) |=> loader_start_o;
  endproperty
  a_ldr: assert property (p_ldr)
    else $error("loader not started");
endmodule // tug_guard_asserts

// ### tb/tug_dbg_host.sv
module tug_dbg_host (
  input wire logic clk_i, // clock
  output logic start_o, // start
  output logic valid_o, // byte strobe
  output logic [7:0] byte_o // key byte
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle at time zero
  initial
  begin
    start_o = 1'b0;
    valid_o = 1'b0;
    byte_o = 8'h00;
  end
  // start, then eight bytes, byte one first
  task automatic present(input logic [63:0] k, input int gap);
    @(posedge clk_i);
    start_o <= 1'b1;
    for (int n = 0; n < 8; n++)
    begin
      @(posedge clk_i);
      start_o <= 1'b0;
      valid_o <= 1'b1;
      byte_o <= k[8*n+:8];
      repeat (gap)
      begin
        @(posedge clk_i);
        valid_o <= 1'b0;
        byte_o <= ~byte_o; // released line
      end
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    byte_o <= ~byte_o;
  endtask
endmodule // tug_dbg_host

// ### tb/tug_guard_bench.sv
module tug_guard_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic code_programmed_i = 1'b1;
  logic [31:0] wb_dat_o, q;
  logic [31:0] s = 32'd71;
  logic [63:0] key;
  logic [7:0] dbg_byte_i;
  logic wb_ack_o, dbg_start_i, dbg_byte_valid_i;
  logic access_grant_o, erase_o, loader_start_o;
  int fails = 0, compares = 0, cyc_n = 0, ers, m_ers, g, lk;
  int m[14];
  always #10 clk_i = ~clk_i;
  tug_guard tug_guard_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .dbg_start_i, .dbg_byte_valid_i, .dbg_byte_i, .code_programmed_i,
    .access_grant_o, .erase_o, .loader_start_o);
  tug_dbg_host tug_dbg_host_i (.clk_i, .start_o(dbg_start_i),
    .valid_o(dbg_byte_valid_i), .byte_o(dbg_byte_i));
  // erase pulses and run limit
  always @(posedge clk_i)
  begin
    cyc_n++;
    if (erase_o === 1'b1)
      ers++;
    if (cyc_n == 4000)
    begin
      fails++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic cycle, held until ack
  task automatic bus(input logic w, input int a, input int d,
                     input logic [3:0] sl);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= 8'(a * 4);
    wb_dat_i <= 32'(d);
    wb_sel_i <= sl;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // model update, then the write
  task automatic wr(input int a, input int d);
    if (a < 8 || a == 9 || a == 10)
      m[a] = d;
    if (a == 8 && m[11] % 16 == 5)
      m[a] = d;
    if ((a == 11 || a == 12) && lk == 0)
      m[a] = d;
    if (m[11] == 8'haa && m[12] == 8'h55)
      lk = 1;
    bus(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input int a);
    int e;
    e = a < 13 ? m[a] : 0;
    if (a == 13)
      e = g + 2 * lk + 4 * (m[11] % 16 == 5) + 16 * (m_ers > 0);
    for (int i = 0; i < 8; i++)
      if (a == 13 && (m[i] == 0 || m[i] == 255))
        e |= 8;
    bus(1'b0, a, 0, 4'h1);
    chk(q, 32'(e));
  endtask
  // key presentation and model verdict
  task automatic pres(input logic [63:0] k, input int gap);
    tug_dbg_host_i.present(k, gap);
    repeat (4) @(posedge clk_i);
    if (m[11] % 16 != 5 && lk == 0 && g == 0)
    begin
      if (k == key)
        g = 1;
      else if (m[8] < 8)
      begin
        m[8]++;
        if (m[8] == 8)
          m_ers++;
      end
    end
    chk(32'(access_grant_o), 32'(g));
    chk(32'(ers), 32'(m_ers));
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    m = '{12: 255, default: 0};
    {g, lk, m_ers, ers} = '0;
  endtask
  task automatic setkey();
    for (int i = 0; i < 8; i++)
    begin
      key[8*i+:8] = 8'(xs() % 254 + 1);
      wr(i, key[8*i+:8]);
    end
  endtask
  task automatic end_sim();
    $display("counts: %0d compares, %0d fails", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    do_reset();
    for (int i = 0; i < 15; i++)
      rd(i);
    setkey();
    bus(1'b1, 0, int'(~key[7:0]), 4'he);
    for (int i = 0; i < 8; i++)
      rd(i);
    $display("test registers done");
    // preset only while disabled, then wrong and right keys
    wr(8, 6);
    rd(8);
    wr(11, 5);
    wr(8, 6);
    pres(key ^ 64'h1, 0);
    wr(11, 0);
    pres(key ^ (64'h80 << 8 * (xs() % 8)), 1);
    pres(key, 0);
    pres(key ^ 64'h2, 0);
    rd(8);
    rd(13);
    $display("test unlock done");
    // count up to the limit and stop there
    do_reset();
    setkey();
    wr(11, 5);
    wr(8, 7);
    wr(11, 0);
    pres(key ^ 64'h4, 2);
    pres(key ^ 64'h4, 0);
    rd(8);
    rd(13);
    $display("test erase done");
    // loader pair against code presence
    for (int i = 0; i < 8; i++)
    begin
      code_programmed_i <= i[2];
      wr(9, i[0] ? 8'h55 : 8'h54);
      wr(10, i[1] ? 8'haa : 8'hab);
      repeat (2) @(posedge clk_i);
      chk(32'(loader_start_o), 32'(i % 4 == 3 || i < 4));
    end
    $display("test loader done");
    // permanent lock freezes option and refuses keys
    wr(11, 8'haa);
    wr(12, 8'h55);
    wr(11, 5);
    rd(11);
    rd(13);
    pres(key, 0);
    $display("test lock done");
    end_sim();
  end
endmodule // tug_guard_bench
bind tug_guard tug_guard_asserts tug_guard_asserts_i (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .dbg_byte_valid_i,
  .code_programmed_i, .access_grant_o, .erase_o, .loader_start_o);
